// [hdl/ccirq_regs.svh]
/*
  Register offsets, field positions, masks and reset values of the clock
  configuration and clock interrupt block.
  Assumes it is included by bare name from the design files.
*/
`ifndef CCIRQ_REGS_SVH
`define CCIRQ_REGS_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define CCIRQ_OFF_CFG      8'h04
`define CCIRQ_OFF_INT      8'h08
`define CCIRQ_OFF_RST      8'h0c
`define CCIRQ_OFF_AUX      8'h2c

// ==========================================================================
// Reset values and masks
`define CCIRQ_RESET_VAL    32'h0000_0000
`define CCIRQ_CFG_NOSTORE  32'h0002_000c
`define CCIRQ_CFG_USB_MASK 32'h80c0_0000
`define CCIRQ_RST_MASK     32'hb038_fffd
`define CCIRQ_AUX_MASK     32'h6000_000f

// ==========================================================================
// Field positions
`define CCIRQ_CFG_PRDV_BIT 17
`define CCIRQ_CFG_PSEL_BIT 16
`define CCIRQ_AUX_ADC_BIT  29
`define CCIRQ_AUX_PRE_BIT  30
`define CCIRQ_INT_IEN_LSB  8
`define CCIRQ_INT_CLR_LSB  16
`define CCIRQ_STUCK_BIT    7

// ==========================================================================
// Bus responses
`define CCIRQ_RESP_OKAY    2'b00
`define CCIRQ_RESP_SLVERR  2'b10

`endif

// [hdl/ccirq_pkg.sv]
/*
  Types shared by the clock configuration block and its clock switch.
  Assumes nothing of its surroundings.
*/
package ccirq_pkg;
  // ========================================================================
  // Types
  typedef enum logic [1:0] {SW_IDLE, SW_WAIT} ccirq_sw_state_type;
  typedef enum logic [1:0] {
    SRC_RC8, SRC_XTAL, SRC_PLL, SRC_RSVD
  } ccirq_src_type;
endpackage : ccirq_pkg

// [hdl/ccirq_sw_if.sv]
/*
  Link between the register block and the system clock switch.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface ccirq_sw_if;
  logic [1:0] target;
  logic [2:0] stable;
  logic       force_rc8;
  logic [1:0] status;
  modport ctrl (output target, output stable, output force_rc8,
                input status);
  modport sw   (input target, input stable, input force_rc8,
                output status);
endinterface : ccirq_sw_if

// [hdl/ccirq_switch.sv]
/*
  System clock switch: follows the requested source once it is stable.
  Assumes stable flags are synchronous and ordered rc8, crystal, pll.
*/
`timescale 1ns/1ps
module ccirq_switch
  import ccirq_pkg::*;
(
  // Clock and reset
  input wire logic  clk,
  input wire logic  arst_n,
  // Link to the register block
  ccirq_sw_if.sw    sw
);
  ccirq_sw_state_type state_reg, state_next;
  logic [1:0]         status_reg, status_next;

  // ========================================================================
  // Switch sequencing
  // Except on a forced switch to rc8, the old source keeps running until the
  // new one is stable; a code of three is reserved and never taken.
  always_comb begin
    state_next  = state_reg;
    status_next = status_reg;
    if (sw.force_rc8) begin
      status_next = SRC_RC8;
      state_next  = SW_IDLE;
    end else begin
      case (state_reg)
        SW_IDLE: begin
          if (sw.target != status_reg && sw.target != SRC_RSVD) begin
            state_next = SW_WAIT;
          end
        end
        SW_WAIT: begin
          if (sw.target == status_reg || sw.target == SRC_RSVD) begin
            state_next = SW_IDLE;
          end else if (sw.stable[sw.target]) begin
            status_next = sw.target;
            state_next  = SW_IDLE;
          end
        end
        default: state_next = SW_IDLE;
      endcase
    end
  end

  // State registers.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg  <= SW_IDLE;
      status_reg <= 2'h0;
    end else begin
      state_reg  <= state_next;
      status_reg <= status_next;
    end
  end

  assign sw.status = status_reg;

  // ========================================================================
  // Checks
  a_force_to_rc8: assert property (@(posedge clk) disable iff (!arst_n)
    sw.force_rc8 |=> status_reg == 2'h0) else $error("no forced rc8");
  a_switch_waits: assert property (@(posedge clk) disable iff (!arst_n)
    state_reg == SW_WAIT && !sw.force_rc8 && !sw.stable[sw.target]
    |=> $stable(status_reg)) else $error("switched early");
  c_switch_done: cover property (@(posedge clk) disable iff (!arst_n)
    state_reg == SW_WAIT ##1 state_reg == SW_IDLE);
endmodule : ccirq_switch

// [hdl/ccirq_top.sv]
/*
  Clock configuration and clock interrupt registers behind AXI4-Lite.
  Assumes oscillator stable, stuck and wake inputs are synchronous to clk.
*/
`timescale 1ns/1ps
`include "ccirq_regs.svh"
module ccirq_top
  import ccirq_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Oscillator and power events
  input  wire logic [6:0]        src_stable,
  input  wire logic              fast_crystal_stuck,
  input  wire logic              low_power_exit,
  input  wire logic              usb_hs_clk_en,
  // Clock tree settings
  output logic [1:0]             sysclk_sel,
  output logic [9:0]             ahb_divisor,
  output logic [4:0]             apb1_divisor,
  output logic [4:0]             apb2_divisor,
  output logic                   adc_from_ahb,
  output logic [4:0]             adc_divisor,
  output logic [3:0]             usb_hs_div_half,
  output logic [7:0]             pll_mult_half,
  output logic [1:0]             pll_source,
  output logic [3:0]             pll_input_predivider,
  output logic [3:0]             clkout_select,
  output logic                   clkout_enable,
  // Resets and interrupts
  output logic [31:0]            apb2_periph_reset,
  output logic                   clock_irq,
  output logic                   clock_nmi
);
  ccirq_sw_if swl ();

  // ========================================================================
  // Decoders
  function automatic logic [9:0] f_ahb(input logic [3:0] c);
    logic [3:0] sh;
    sh = c[2] ? {2'h0, c[1:0]} + 4'h6 : {2'h0, c[1:0]} + 4'h1;
    return c[3] ? (10'h001 << sh) : 10'h001;
  endfunction : f_ahb

  function automatic logic [4:0] f_apb(input logic [2:0] c);
    return c[2] ? (5'h02 << c[1:0]) : 5'h01;
  endfunction : f_apb

  function automatic logic [4:0] f_adc(input logic [3:0] c);
    logic [4:0] d;
    d = 5'h02;
    case (c)
      4'h0, 4'h4: d = 5'h02;
      4'h1:       d = 5'h04;
      4'h2:       d = 5'h06;
      4'h3, 4'h6: d = 5'h08;
      4'h5:       d = 5'h0c;
      4'h7:       d = 5'h10;
      default: begin
        case (c[1:0])
          2'h0:    d = 5'h05;
          2'h1:    d = 5'h06;
          2'h2:    d = 5'h0a;
          default: d = 5'h14;
        endcase
      end
    endcase
    return d;
  endfunction : f_adc

  // Divisor counted in halves, so 1.5 reads as 3.
  function automatic logic [3:0] f_usb(input logic [2:0] c);
    logic [3:0] d;
    case (c)
      3'h0:    d = 4'h3;
      3'h1:    d = 4'h2;
      3'h2:    d = 4'h5;
      3'h3:    d = 4'h4;
      3'h4:    d = 4'h6;
      3'h5:    d = 4'h7;
      default: d = 4'h8;
    endcase
    return d;
  endfunction : f_usb

  // Multiplier counted in halves, so 6.5 reads as 13.
  function automatic logic [7:0] f_mult(input logic [5:0] c);
    logic [7:0] d;
    if (c <= 6'h0c) begin
      d = {1'b0, c, 1'b0} + 8'h04;
    end else if (c == 6'h0d) begin
      d = 8'h0d;
    end else if (c <= 6'h0f) begin
      d = 8'h20;
    end else begin
      d = {1'b0, c, 1'b0} + 8'h02;
    end
    return d;
  endfunction : f_mult

  function automatic logic [31:0] f_mask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : f_mask

  // ========================================================================
  // Registers and bus state
  logic [31:0]       cfg_reg, cfg_next, aux_reg, aux_next;
  logic [31:0]       rst_reg, rst_next, rdata_reg, rdata_next;
  logic [6:0]        ien_reg, ien_next, prev_reg, prev_next;
  logic [7:0]        flag_reg, flag_next, flag_set, flag_clr;
  logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [31:0]       wdata_reg, wdata_next;
  logic [3:0]        wstrb_reg, wstrb_next;
  logic              awh_reg, awh_next, wh_reg, wh_next;
  logic              bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic              arready_reg, arready_next, awready_reg, wready_reg;
  logic [1:0]        bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [9:0]        ahb_reg;
  logic [4:0]        apb1_reg, apb2_reg, adcd_reg;
  logic [3:0]        usb_reg, clko_reg;
  logic [7:0]        mult_reg;
  logic [1:0]        psrc_reg;
  logic              adc_ahb_reg, clken_reg, irq_reg, nmi_reg;
  logic              wr_fire, force_rc8, xtal_in_use;
  logic [31:0]       wmask;
  logic [3:0]        adc_code;

  assign wr_fire = awh_reg & wh_reg & ~bvalid_reg;
  assign wmask   = f_mask(wstrb_reg);

  // The crystal feeds the system clock directly or through the PLL.
  assign xtal_in_use = swl.status == SRC_XTAL ||
    (swl.status == SRC_PLL && cfg_reg[`CCIRQ_CFG_PSEL_BIT] &&
     !aux_reg[`CCIRQ_AUX_PRE_BIT]);
  assign force_rc8 = low_power_exit | (fast_crystal_stuck & xtal_in_use);

  assign swl.target    = cfg_reg[1:0];
  assign swl.stable    = {src_stable[4], src_stable[3], src_stable[2]};
  assign swl.force_rc8 = force_rc8;

  ccirq_switch u_switch (
    .clk    (clk),
    .arst_n (arst_n),
    .sw     (swl.sw)
  );

  // Flag set per source: only on a rising stable level with enable on.
  for (genvar i = 0; i < 7; i++) begin : g_flag
    assign flag_set[i] = src_stable[i] & ~prev_reg[i] & ien_reg[i];
  end
  assign flag_set[`CCIRQ_STUCK_BIT] = fast_crystal_stuck;

  // ========================================================================
  // Register writes, flags and bus handshake
  always_comb begin
    cfg_next    = cfg_reg;
    aux_next    = aux_reg;
    rst_next    = rst_reg;
    ien_next    = ien_reg;
    flag_clr    = 8'h00;
    awaddr_next = awaddr_reg;
    wdata_next  = wdata_reg;
    wstrb_next  = wstrb_reg;
    awh_next    = awh_reg;
    wh_next     = wh_reg;
    bvalid_next = bvalid_reg;
    bresp_next  = bresp_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      awaddr_next = s_axi_awaddr;
      awh_next    = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
      wh_next    = 1'b1;
    end
    if (wr_fire) begin
      awh_next    = 1'b0;
      wh_next     = 1'b0;
      bvalid_next = 1'b1;
      bresp_next  = `CCIRQ_RESP_OKAY;
      case ({awaddr_reg[ADDR_W-1:2], 2'h0})
        `CCIRQ_OFF_CFG: begin
          cfg_next = ((cfg_reg & ~wmask) | (wdata_reg & wmask))
                     & ~`CCIRQ_CFG_NOSTORE;
          if (usb_hs_clk_en) begin
            cfg_next = (cfg_next & ~`CCIRQ_CFG_USB_MASK) |
                       (cfg_reg & `CCIRQ_CFG_USB_MASK);
          end
          if (wstrb_reg[2]) begin
            aux_next[0] = wdata_reg[`CCIRQ_CFG_PRDV_BIT];
          end
        end
        `CCIRQ_OFF_AUX: aux_next = ((aux_reg & ~wmask) |
                                   (wdata_reg & wmask)) & `CCIRQ_AUX_MASK;
        `CCIRQ_OFF_INT: begin
          if (wstrb_reg[1]) begin
            ien_next = wdata_reg[`CCIRQ_INT_IEN_LSB +: 7];
          end
          if (wstrb_reg[2]) begin
            flag_clr = wdata_reg[`CCIRQ_INT_CLR_LSB +: 8];
          end
        end
        `CCIRQ_OFF_RST: rst_next = ((rst_reg & ~wmask) |
                                   (wdata_reg & wmask)) & `CCIRQ_RST_MASK;
        default: bresp_next = `CCIRQ_RESP_SLVERR;
      endcase
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (force_rc8) begin
      cfg_next[1:0] = SRC_RC8;
    end
    // A set in the same cycle as its clear wins.
    flag_next = (flag_reg & ~flag_clr) | flag_set;
    prev_next = src_stable;
  end

  // ========================================================================
  // Read path
  always_comb begin
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    rvalid_next  = rvalid_reg;
    arready_next = arready_reg;
    if (s_axi_arvalid && arready_reg) begin
      rvalid_next  = 1'b1;
      arready_next = 1'b0;
      rresp_next   = `CCIRQ_RESP_OKAY;
      rdata_next   = 32'h0000_0000;
      case ({s_axi_araddr[ADDR_W-1:2], 2'h0})
        `CCIRQ_OFF_CFG: begin
          rdata_next = cfg_reg;
          rdata_next[`CCIRQ_CFG_PRDV_BIT] = aux_reg[0];
          rdata_next[3:2] = swl.status;
        end
        `CCIRQ_OFF_INT: rdata_next = {17'h00000, ien_reg, flag_reg};
        `CCIRQ_OFF_RST: rdata_next = rst_reg;
        `CCIRQ_OFF_AUX: rdata_next = aux_reg;
        default: rresp_next = `CCIRQ_RESP_SLVERR;
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next  = 1'b0;
      arready_next = 1'b1;
    end
  end

  assign adc_code = {aux_next[`CCIRQ_AUX_ADC_BIT], cfg_next[28],
                     cfg_next[15:14]};

  // All registers; decoded settings are registered from next values so
  // every output leaves a flip-flop.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_reg     <= `CCIRQ_RESET_VAL;
      aux_reg     <= `CCIRQ_RESET_VAL;
      rst_reg     <= `CCIRQ_RESET_VAL;
      ien_reg     <= 7'h00;
      flag_reg    <= 8'h00;
      prev_reg    <= 7'h00;
      awaddr_reg  <= '0;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      awh_reg     <= 1'b0;
      wh_reg      <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= 2'h0;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= 2'h0;
      rdata_reg   <= 32'h0000_0000;
      arready_reg <= 1'b1;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      ahb_reg     <= 10'h001;
      apb1_reg    <= 5'h01;
      apb2_reg    <= 5'h01;
      adcd_reg    <= 5'h02;
      adc_ahb_reg <= 1'b0;
      usb_reg     <= 4'h3;
      mult_reg    <= 8'h04;
      psrc_reg    <= 2'h0;
      clko_reg    <= 4'h0;
      clken_reg   <= 1'b0;
      irq_reg     <= 1'b0;
      nmi_reg     <= 1'b0;
    end else begin
      cfg_reg     <= cfg_next;
      aux_reg     <= aux_next;
      rst_reg     <= rst_next;
      ien_reg     <= ien_next;
      flag_reg    <= flag_next;
      prev_reg    <= prev_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      awh_reg     <= awh_next;
      wh_reg      <= wh_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
      arready_reg <= arready_next;
      awready_reg <= ~awh_next & ~bvalid_next;
      wready_reg  <= ~wh_next & ~bvalid_next;
      ahb_reg     <= f_ahb(cfg_next[7:4]);
      apb1_reg    <= f_apb(cfg_next[10:8]);
      apb2_reg    <= f_apb(cfg_next[13:11]);
      adcd_reg    <= f_adc(adc_code);
      adc_ahb_reg <= adc_code[3];
      usb_reg     <= f_usb({cfg_next[31], cfg_next[23:22]});
      mult_reg    <= f_mult({cfg_next[30:29], cfg_next[21:18]});
      psrc_reg    <= !cfg_next[`CCIRQ_CFG_PSEL_BIT] ? 2'h0 :
                     (aux_next[`CCIRQ_AUX_PRE_BIT] ? 2'h2 : 2'h1);
      clko_reg    <= cfg_next[27:24];
      clken_reg   <= cfg_next[27:26] != 2'h0 && cfg_next[27:24] != 4'hf;
      irq_reg     <= |flag_next[6:0];
      nmi_reg     <= flag_next[`CCIRQ_STUCK_BIT];
    end
  end

  // ========================================================================
  // Outputs
  assign s_axi_awready        = awready_reg;
  assign s_axi_wready         = wready_reg;
  assign s_axi_bvalid         = bvalid_reg;
  assign s_axi_bresp          = bresp_reg;
  assign s_axi_arready        = arready_reg;
  assign s_axi_rvalid         = rvalid_reg;
  assign s_axi_rresp          = rresp_reg;
  assign s_axi_rdata          = rdata_reg;
  assign sysclk_sel           = swl.status;
  assign ahb_divisor          = ahb_reg;
  assign apb1_divisor         = apb1_reg;
  assign apb2_divisor         = apb2_reg;
  assign adc_from_ahb         = adc_ahb_reg;
  assign adc_divisor          = adcd_reg;
  assign usb_hs_div_half      = usb_reg;
  assign pll_mult_half        = mult_reg;
  assign pll_source           = psrc_reg;
  assign pll_input_predivider = aux_reg[3:0];
  assign clkout_select        = clko_reg;
  assign clkout_enable        = clken_reg;
  assign apb2_periph_reset    = rst_reg;
  assign clock_irq            = irq_reg;
  assign clock_nmi            = nmi_reg;

  // ========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_ready_flag_set: assert property ($rose(src_stable[4]) && ien_reg[4]
    |=> flag_reg[4]) else $error("ready flag missed");
  a_stuck_flag_set: assert property (fast_crystal_stuck
    |=> flag_reg[7] && clock_nmi) else $error("stuck flag missed");
  a_flag_w1c: assert property (wr_fire && awaddr_reg == `CCIRQ_OFF_INT
    && wstrb_reg[2] && wdata_reg[16] && !flag_set[0] |=> !flag_reg[0])
    else $error("flag not cleared");
  a_irq_level: assert property (clock_irq == |flag_reg[6:0])
    else $error("irq mismatch");
  a_usb_frozen: assert property (usb_hs_clk_en |=> $stable(cfg_reg[31])
    && $stable(cfg_reg[23:22])) else $error("usb div changed");
  a_ahb_div_max: assert property (cfg_reg[7:4] == 4'hf
    |-> ahb_divisor == 10'h200) else $error("ahb divisor");
  a_apb1_div_max: assert property (cfg_reg[10:8] == 3'h7
    |-> apb1_divisor == 5'h10) else $error("apb1 divisor");
  a_apb2_div_pass: assert property (!cfg_reg[13]
    |-> apb2_divisor == 5'h01) else $error("apb2 divisor");
  a_pll_half_mult: assert property ({cfg_reg[30:29], cfg_reg[21:18]}
    == 6'h0d |-> pll_mult_half == 8'h0d) else $error("pll mult");
  a_adc_ahb_twenty: assert property (adc_code[3] && adc_code[1:0] == 2'h3
    |=> adc_from_ahb && adc_divisor == 5'h14) else $error("adc");
  a_clkout_none: assert property (cfg_reg[27:26] == 2'h0
    |-> !clkout_enable) else $error("clkout enabled");
  c_flag_cleared: cover property (flag_reg[4] ##1 !flag_reg[4]);
  c_stuck_force: cover property (fast_crystal_stuck && xtal_in_use);
  c_read_done: cover property (s_axi_rvalid && s_axi_rready);
endmodule : ccirq_top

// [sim/ccirq_top_tb.sv]
/*
  Self-checking bench for the clock configuration and clock interrupt block.
  Assumes the design files and ccirq_regs.svh are compiled first.
*/
`timescale 1ns/1ps
`include "ccirq_regs.svh"
module ccirq_top_tb;
  // ========================================================================
  // Signals
  logic        clk = 1'b0, arst_n = 1'b0;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, fast_crystal_stuck;
  logic        low_power_exit, usb_hs_clk_en, adc_from_ahb, clkout_enable;
  logic        clock_irq, clock_nmi;
  logic [31:0] s_axi_wdata, s_axi_rdata, apb2_periph_reset;
  logic [3:0]  s_axi_wstrb, usb_hs_div_half, pll_input_predivider;
  logic [3:0]  clkout_select;
  logic [1:0]  s_axi_bresp, s_axi_rresp, sysclk_sel, pll_source;
  logic [6:0]  src_stable;
  logic [9:0]  ahb_divisor;
  logic [4:0]  apb1_divisor, apb2_divisor, adc_divisor;
  logic [7:0]  pll_mult_half;
  logic [31:0] seed = 32'h0000_004d, w, cfg_m, aux_m;
  int          n_errors = 0, compares = 0, cyc = 0;
  localparam logic [4:0] ADC_A[4] = '{5'h05, 5'h06, 5'h0a, 5'h14};
  localparam logic [4:0] ADC_P[8] = '{5'h02, 5'h04, 5'h06, 5'h08,
                                      5'h02, 5'h0c, 5'h08, 5'h10};

  ccirq_top dut (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .src_stable, .fast_crystal_stuck,
    .low_power_exit, .usb_hs_clk_en, .sysclk_sel, .ahb_divisor,
    .apb1_divisor, .apb2_divisor, .adc_from_ahb, .adc_divisor,
    .usb_hs_div_half, .pll_mult_half, .pll_source, .pll_input_predivider,
    .clkout_select, .clkout_enable, .apb2_periph_reset, .clock_irq,
    .clock_nmi);

  // The clock runs at 40 MHz; the cycle count cuts short any hang.
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end

  // ========================================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic [7:0] f_mult(input logic [5:0] m);
    if (m < 6'h0d) return 8'(2 * m + 4);
    if (m == 6'h0d) return 8'h0d;
    if (m < 6'h10) return 8'h20;
    return 8'(2 * m + 2);
  endfunction : f_mult

  function automatic logic [3:0] f_usb(input logic [2:0] u);
    if (u >= 3'h6) return 4'h8;
    if (u >= 3'h4) return 4'(u + 2);
    return (u == 3'h0) ? 4'h3 : (u == 3'h1) ? 4'h2 : (u == 3'h2) ? 4'h5 : 4'h4;
  endfunction : f_usb

  function automatic logic [4:0] f_apb(input logic [2:0] c);
    return c[2] ? 5'h02 << c[1:0] : 5'h01;
  endfunction : f_apb

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Each channel is released only at the edge where its ready is seen high.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
  endtask : rd

  task automatic conclude();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  // ========================================================================
  // Main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, fast_crystal_stuck, low_power_exit, usb_hs_clk_en} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, src_stable} = '0;
    s_axi_wstrb = 4'hf;
    {cfg_m, aux_m} = '0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    rd(`CCIRQ_OFF_INT, 32'h0, `CCIRQ_RESP_OKAY);
    // Random configuration words, some while the USB clock is enabled.
    // Bits 1:0 stay zero, so the PLL never clocks the system here.
    for (int i = 0; i < 60; i++) begin
      if (i % 4 == 1) begin
        w = xs() & `CCIRQ_AUX_MASK;
        wr(`CCIRQ_OFF_AUX, w, `CCIRQ_RESP_OKAY);
        aux_m = w;
      end
      w = xs() & 32'hffff_fffc;
      if (i == 0) w = 32'h0f34_fff0;
      usb_hs_clk_en <= (i % 3 == 0);
      wr(`CCIRQ_OFF_CFG, w, `CCIRQ_RESP_OKAY);
      if (usb_hs_clk_en)
        w = (w & ~`CCIRQ_CFG_USB_MASK) | (cfg_m & `CCIRQ_CFG_USB_MASK);
      cfg_m = w;
      aux_m[0] = w[17];
      rd(`CCIRQ_OFF_CFG, (w & ~`CCIRQ_CFG_NOSTORE) |
         (32'(aux_m[0]) << 17), 2'b00);
      rd(`CCIRQ_OFF_AUX, aux_m, `CCIRQ_RESP_OKAY);
      chk("ahb", w[7] ? (w[6] ? 10'h40 << w[5:4] : 10'h2 << w[5:4])
          : 10'h1, ahb_divisor);
      chk("apb1", f_apb(w[10:8]), apb1_divisor);
      chk("apb2", f_apb(w[13:11]), apb2_divisor);
      chk("mult", f_mult({w[30:29], w[21:18]}), pll_mult_half);
      chk("usb", f_usb({w[31], w[23:22]}), usb_hs_div_half);
      chk("adc", aux_m[29] ? {1'b1, ADC_A[w[15:14]]} :
          {1'b0, ADC_P[{w[28], w[15:14]}]}, {adc_from_ahb, adc_divisor});
      chk("ckout", {w[27:24] >= 4'h4 && w[27:24] <= 4'he, w[27:24]},
          {clkout_enable, clkout_select});
      chk("psrc", w[16] ? (aux_m[30] ? 2'h2 : 2'h1) : 2'h0, pll_source);
      chk("predv", aux_m[3:0], pll_input_predivider);
    end
    w = xs();
    wr(`CCIRQ_OFF_RST, w, `CCIRQ_RESP_OKAY);
    rd(`CCIRQ_OFF_RST, w & `CCIRQ_RST_MASK, `CCIRQ_RESP_OKAY);
    chk("prst", w & `CCIRQ_RST_MASK, apb2_periph_reset);
    wr(8'h40, w, `CCIRQ_RESP_SLVERR);
    rd(8'h40, 32'h0, `CCIRQ_RESP_SLVERR);
    // Switch waits for a stable crystal, then falls back on stuck or wake.
    for (int k = 0; k < 2; k++) begin
      wr(`CCIRQ_OFF_CFG, 32'h1, `CCIRQ_RESP_OKAY);
      repeat (4) @(posedge clk);
      chk("sw_wait", 2'b00, sysclk_sel);
      src_stable[3] <= 1'b1;
      for (int j = 0; j < 20 && sysclk_sel !== 2'b01; j++) @(posedge clk);
      chk("sw_done", 2'b01, sysclk_sel);
      if (k == 0) fast_crystal_stuck <= 1'b1;
      else low_power_exit <= 1'b1;
      @(posedge clk);
      {fast_crystal_stuck, low_power_exit, src_stable} <= '0;
      @(posedge clk);
      chk("sw_force", 2'b00, sysclk_sel);
      chk("nmi", 1'b1, clock_nmi);
      chk("irq", 1'b0, clock_irq);
    end
    // Only byte 1 strobed: the clear byte must be ignored.
    s_axi_wstrb <= 4'h2;
    wr(`CCIRQ_OFF_INT, 32'h0080_7f00, `CCIRQ_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(`CCIRQ_OFF_INT, 32'h7f80, `CCIRQ_RESP_OKAY);
    wr(`CCIRQ_OFF_INT, 32'h0080_0000, `CCIRQ_RESP_OKAY);
    chk("nmi_clr", 1'b0, clock_nmi);
    // Every ready flag is raised, survives a zero write, then is cleared.
    wr(`CCIRQ_OFF_INT, 32'h7f00, `CCIRQ_RESP_OKAY);
    for (int i = 0; i < 7; i++) begin
      src_stable[i] <= 1'b1;
      repeat (3) @(posedge clk);
      chk("irq_set", 1'b1, clock_irq);
      wr(`CCIRQ_OFF_INT, 32'h7f00, `CCIRQ_RESP_OKAY);
      rd(`CCIRQ_OFF_INT, 32'h7f00 | (32'h1 << i), 2'b00);
      wr(`CCIRQ_OFF_INT, 32'h7f00 | (32'h1_0000 << i), 2'b00);
      chk("irq_clr", 1'b0, clock_irq);
    end
    wr(`CCIRQ_OFF_INT, 32'h0, `CCIRQ_RESP_OKAY);
    src_stable <= '0;
    repeat (2) @(posedge clk);
    src_stable <= 7'h7f;
    repeat (3) @(posedge clk);
    rd(`CCIRQ_OFF_INT, 32'h0, `CCIRQ_RESP_OKAY);
    conclude();
  end
endmodule : ccirq_top_tb
